// ===== sbc_host_model.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Processor side of the shared data and parity wires

module sbc_host_model (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire sbc_pkg::sbc_word_t dut_word,
	input  wire logic               dut_oe,
	input  wire sbc_pkg::sbc_word_t host_word,
	input  wire logic               host_oe,
	output sbc_pkg::sbc_word_t      wire_word,
	output int                      clash_cnt
);
	sbc_pkg::sbc_word_t last_q;

	// Released wires toggle every cycle so a stale word never passes for a read
	always_comb
	begin
		if (dut_oe)
			wire_word = dut_word;
		else if (host_oe)
			wire_word = host_word;
		else
			wire_word = ~last_q;
	end

	// Both ends driving at once is a turnaround fault on one side
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			clash_cnt <= 0;
		else if (dut_oe && host_oe)
			clash_cnt <= clash_cnt + 1;
	end

	// Remember the last level seen on the wires
	always_ff @(posedge core_clk)
	begin
		last_q <= wire_word;
	end
endmodule

// ===== sbc_pkg.sv
package sbc_pkg;

	// Geometry of the array and its word
	localparam int ADDR_W     = 17;
	localparam int LANES      = 4;
	localparam int LANE_W     = 8;
	localparam int DATA_W     = LANES * LANE_W;
	localparam int HI_W       = ADDR_W - 2;
	localparam int FIFO_DEPTH = 16;

	// Burst order select level that picks the interleaved sequence
	localparam logic       ORDER_INTERLEAVE = 1'b1;
	localparam logic [1:0] BURST_FIRST      = 2'h0;
	localparam logic [1:0] BURST_STEP       = 2'h1;
	localparam logic [3:0] ALL_LANES        = 4'hf;
	localparam logic [3:0] NO_LANES_N       = 4'hf;

	// One word as it sits on the pins: parity above data
	typedef struct packed {
		logic [LANES-1:0]  parity;
		logic [DATA_W-1:0] data;
	} sbc_word_t;

	// A posted write waiting to reach the array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  lanes;
		sbc_word_t         word;
	} sbc_post_t;

endpackage

// ===== sbc_sram_port.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Posting buffer between the pin capture and the array

module sbc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output wire logic             in_ready,
	output wire logic             out_valid,
	output wire logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	// DEPTH must be a power of two; the extra pointer bit tells full from empty
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_q [DEPTH];
	logic [PW:0]      wr_ptr_q;
	logic [PW:0]      rd_ptr_q;
	logic             full_c;
	logic             empty_c;

	// Honest flags from the pointers
	assign full_c    = (wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
	assign empty_c   = (wr_ptr_q == rd_ptr_q);
	assign in_ready  = !full_c;
	assign out_valid = !empty_c;
	assign out_data  = store_q[rd_ptr_q[PW-1:0]];

	// Storage needs no reset, only the pointers do
	always_ff @(posedge core_clk)
	begin
		if (in_valid && !full_c)
			store_q[wr_ptr_q[PW-1:0]] <= in_data;
	end

	// Pointer update
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end
		else
		begin
			if (in_valid && !full_c)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (out_ready && !empty_c)
				rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end

	fifo_full_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		full_c |=> !(in_valid && !in_ready) || (wr_ptr_q == $past(wr_ptr_q)))
		else $error("fifo pointer moved while full");

endmodule

////////////////////////////////////////////////////////////////////////////////
// Synchronous burst cache memory behind its pins

module sbc_sram_port #(
	parameter int ADDR_W     = sbc_pkg::ADDR_W,
	parameter int FIFO_DEPTH = sbc_pkg::FIFO_DEPTH
) (
	input  wire logic                           core_clk,
	input  wire logic                           rst_n,
	input  wire logic [ADDR_W-1:0]              addr,
	input  wire logic                           cpu_addr_strobe_n,
	input  wire logic                           ctrl_addr_strobe_n,
	input  wire logic                           burst_advance_n,
	input  wire logic                           write_all_lanes_n,
	input  wire logic                           lane_write_enable_n,
	input  wire logic [sbc_pkg::LANES-1:0]      lane_select_n,
	input  wire logic                           select_low_a_n,
	input  wire logic                           select_high_b,
	input  wire logic                           select_low_c_n,
	input  wire logic                           out_enable_n,
	input  wire logic                           sleep_request,
	input  wire logic                           burst_order,
	input  wire logic [sbc_pkg::DATA_W-1:0]     data_in,
	output wire logic [sbc_pkg::DATA_W-1:0]     data_out,
	output wire logic                           data_oe,
	input  wire logic [sbc_pkg::LANES-1:0]      parity_lines_in,
	output wire logic [sbc_pkg::LANES-1:0]      parity_lines_out,
	output wire logic                           parity_lines_oe,
	output wire logic                           write_buffer_ready
);
	localparam int HI_W = ADDR_W - 2;
	localparam int PW   = ADDR_W + sbc_pkg::LANES + sbc_pkg::DATA_W + sbc_pkg::LANES;

	sbc_pkg::sbc_word_t mem_q [2**ADDR_W];

	logic                      sleep_meta_q;
	logic                      sleep_q;
	logic                      awake_c;
	logic                      sel_c;
	logic                      cpu_addr_strobe_n_go_c;
	logic                      ctrl_addr_strobe_n_go_c;
	logic                      start_c;
	logic                      desel_c;
	logic                      wr_req_c;
	logic                      wr_c;
	logic                      active_q;
	logic                      active_d;
	logic [HI_W-1:0]           addr_hi_q;
	logic [HI_W-1:0]           addr_hi_d;
	logic [1:0]                start_q;
	logic [1:0]                start_d;
	logic [1:0]                cnt_q;
	logic [1:0]                cnt_d;
	logic [ADDR_W-1:0]         acc_addr_d;
	logic [ADDR_W-1:0]         acc_addr_q;
	logic                      wr_q;
	logic                      rd_valid_q;
	sbc_pkg::sbc_word_t        rd_q;
	sbc_pkg::sbc_word_t        rd_word_c;
	sbc_pkg::sbc_post_t        post_c;
	sbc_pkg::sbc_post_t        head_c;
	sbc_pkg::sbc_word_t        old_c;
	sbc_pkg::sbc_word_t        merged_c;
	logic                      in_ready_c;
	logic                      head_valid_c;
	logic                      drain_c;
	logic                      drive_c;

	// Burst address bits from start value and count
	function automatic logic [1:0] sbc_burst_lsb(input logic [1:0] start, input logic [1:0] cnt,
		input logic order);
		sbc_burst_lsb = (order == sbc_pkg::ORDER_INTERLEAVE) ? (start ^ cnt) : (start + cnt);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Sleep is asynchronous, so it passes two flops; this also gives the two-cycle entry

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sleep_meta_q <= 1'b0;
			sleep_q      <= 1'b0;
		end
		else
		begin
			sleep_meta_q <= sleep_request;
			sleep_q      <= sleep_meta_q;
		end
	end

	assign awake_c = !sleep_q;

	////////////////////////////////////////////////////////////////////////////////
	// Access decode on the pins as sampled this edge

	assign sel_c     = !select_low_a_n && select_high_b && !select_low_c_n;
	assign cpu_addr_strobe_n_go_c = !cpu_addr_strobe_n && !select_low_a_n;
	// The controller strobe counts only with the processor strobe high
	assign ctrl_addr_strobe_n_go_c = !ctrl_addr_strobe_n && cpu_addr_strobe_n;
	assign start_c   = awake_c && sel_c && (cpu_addr_strobe_n_go_c || ctrl_addr_strobe_n_go_c);
	assign desel_c   = awake_c && !start_c && (!cpu_addr_strobe_n || !ctrl_addr_strobe_n);
	assign wr_req_c  = !write_all_lanes_n || (!lane_write_enable_n && (lane_select_n != sbc_pkg::NO_LANES_N));

	// Next access state; everything holds while asleep
	always_comb
	begin
		addr_hi_d = addr_hi_q;
		start_d   = start_q;
		cnt_d     = cnt_q;
		active_d  = active_q;
		wr_c      = 1'b0;
		if (start_c)
		begin
			addr_hi_d = addr[ADDR_W-1:2];
			start_d   = addr[1:0];
			cnt_d     = sbc_pkg::BURST_FIRST;
			active_d  = 1'b1;
			// Processor-strobe edge never writes
			wr_c      = ctrl_addr_strobe_n_go_c && wr_req_c;
		end
		else if (desel_c)
			active_d = 1'b0;
		else if (awake_c && active_q)
		begin
			if (!burst_advance_n)
				cnt_d = cnt_q + sbc_pkg::BURST_STEP;
			wr_c = wr_req_c;
		end
		acc_addr_d = {addr_hi_d, sbc_burst_lsb(start_d, cnt_d, burst_order)};
	end

	// Access registers, all on the rising edge
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_hi_q  <= '0;
			start_q    <= 2'h0;
			cnt_q      <= 2'h0;
			active_q   <= 1'b0;
			acc_addr_q <= '0;
			wr_q       <= 1'b0;
		end
		else
		begin
			addr_hi_q  <= addr_hi_d;
			start_q    <= start_d;
			cnt_q      <= cnt_d;
			active_q   <= active_d;
			acc_addr_q <= acc_addr_d;
			wr_q       <= wr_c;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write capture: the FIFO entry is the data register; a full buffer drops the write

	always_comb
	begin
		post_c.addr        = acc_addr_d;
		post_c.lanes       = !write_all_lanes_n ? sbc_pkg::ALL_LANES : ~lane_select_n;
		post_c.word.data   = data_in;
		post_c.word.parity = parity_lines_in;
	end

	sbc_fifo #(
		.WIDTH (PW),
		.DEPTH (FIFO_DEPTH)
	) u_post (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (wr_c),
		.in_data   (post_c),
		.in_ready  (in_ready_c),
		.out_valid (head_valid_c),
		.out_data  (head_c),
		.out_ready (awake_c)
	);

	assign write_buffer_ready = in_ready_c;
	// Array is frozen while asleep: the drain stalls and the buffer takes no new writes
	assign drain_c = head_valid_c && awake_c;
	assign old_c   = mem_q[head_c.addr];

	// Per-lane merge, each select covering eight data bits and one parity bit
	for (genvar i = 0; i < sbc_pkg::LANES; i++)
	begin : g_lane
		assign merged_c.data[i*sbc_pkg::LANE_W +: sbc_pkg::LANE_W] = head_c.lanes[i] ?
			head_c.word.data[i*sbc_pkg::LANE_W +: sbc_pkg::LANE_W] :
			old_c.data[i*sbc_pkg::LANE_W +: sbc_pkg::LANE_W];
		assign merged_c.parity[i] = head_c.lanes[i] ? head_c.word.parity[i] : old_c.parity[i];
	end

	// Array write port
	always_ff @(posedge core_clk)
	begin
		if (drain_c)
			mem_q[head_c.addr] <= merged_c;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path; forwarding covers a drain landing on the word being read

	assign rd_word_c = (drain_c && (head_c.addr == acc_addr_d)) ? merged_c : mem_q[acc_addr_d];

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_q       <= '0;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_q       <= rd_word_c;
			rd_valid_q <= awake_c && active_d && !wr_c;
		end
	end

	// Pin drive is combinational on output enable so it acts without the clock
	assign drive_c          = rd_valid_q && !out_enable_n && !sleep_q &&
		!(active_q && wr_req_c);
	assign data_out         = rd_q.data;
	assign parity_lines_out = rd_q.parity;
	assign data_oe          = drive_c;
	assign parity_lines_oe  = drive_c;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	select_decode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		start_c |-> (!select_low_a_n && select_high_b && !select_low_c_n))
		else $error("access started without full select");

	global_lanes_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_c && !write_all_lanes_n) |-> (post_c.lanes == 4'hf))
		else $error("global write lost a lane");

	byte_lanes_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_c && write_all_lanes_n) |-> (post_c.lanes == ~lane_select_n) && !lane_write_enable_n)
		else $error("byte write lanes wrong");

	strobe_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(start_c && !cpu_addr_strobe_n) |-> !wr_c ##1 (active_q && cnt_q == 2'h0))
		else $error("write taken on processor strobe edge");

	strobe_priority_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(awake_c && sel_c && !cpu_addr_strobe_n && !ctrl_addr_strobe_n && wr_req_c) |-> !wr_c)
		else $error("controller strobe honoured over processor strobe");

	burst_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(awake_c && active_q && !start_c && !desel_c && !burst_advance_n)
		|=> (cnt_q == 2'($past(cnt_q) + 2'h1)))
		else $error("burst counter did not step");

	burst_order_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(active_q && $stable(burst_order)) |-> (burst_order ?
			((acc_addr_q[1:0] ^ start_q) == cnt_q) : (2'(acc_addr_q[1:0] - start_q) == cnt_q)))
		else $error("burst address off sequence");

	write_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_q |-> !data_oe && !parity_lines_oe)
		else $error("pins driven after a write");

	oe_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		out_enable_n |-> !data_oe)
		else $error("pins driven with output enable high");

	sleep_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		sleep_q |-> !wr_c && !start_c ##1 $stable(cnt_q) && $stable(acc_addr_q))
		else $error("input acted on while asleep");

	sleep_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		sleep_q |-> !drain_c)
		else $error("array written while asleep");

	read_latency_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(start_c && !wr_c && !(drain_c && head_c.addr == acc_addr_d))
		|=> rd_valid_q && (rd_q == $past(mem_q[acc_addr_d])))
		else $error("read data not from address of previous edge");

endmodule

// ===== sbc_sram_port_tb.sv
`timescale 1ns/1ns

module sbc_sram_port_tb;
	localparam logic [2:0]  SEL_OK = 3'h2;
	localparam logic [16:0] A0     = 17'h00103;
	localparam logic [16:0] A1     = 17'h1f0f2;
	localparam logic [16:0] BASE   = 17'h00a04;

	logic               core_clk, rst_n, sp_n, sc_n, adv_n, gw_n, bwe_n;
	logic               oe_n, zz, mode, host_oe, doe, poe, rdy;
	logic [2:0]         sel;
	logic [3:0]         bs_n;
	logic [3:0]         pout;
	logic [16:0]        ad;
	logic [31:0]        dout;
	sbc_pkg::sbc_word_t host_w;
	sbc_pkg::sbc_word_t wire_w;
	sbc_pkg::sbc_word_t mem_e [int];
	int                 clash;
	int                 num_errors;
	int                 checks_done;

	sbc_sram_port #(.ADDR_W(17), .FIFO_DEPTH(16)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .addr(ad), .cpu_addr_strobe_n(sp_n),
		.ctrl_addr_strobe_n(sc_n), .burst_advance_n(adv_n), .write_all_lanes_n(gw_n),
		.lane_write_enable_n(bwe_n), .lane_select_n(bs_n), .select_low_a_n(sel[2]),
		.select_high_b(sel[1]), .select_low_c_n(sel[0]), .out_enable_n(oe_n),
		.sleep_request(zz), .burst_order(mode), .data_in(wire_w.data), .data_out(dout),
		.data_oe(doe), .parity_lines_in(wire_w.parity), .parity_lines_out(pout),
		.parity_lines_oe(poe), .write_buffer_ready(rdy));

	sbc_host_model host_u (.core_clk(core_clk), .rst_n(rst_n), .dut_word({pout, dout}),
		.dut_oe(doe && poe), .host_word(host_w), .host_oe(host_oe), .wire_word(wire_w),
		.clash_cnt(clash));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
		end
	endtask

	task automatic tick;
		@(negedge core_clk);
	endtask

	// Strobes idle but the part stays selected, so an open access carries on
	task automatic idle;
		sp_n = 1;
		sc_n = 1;
		adv_n = 1;
		gw_n = 1;
		bwe_n = 1;
		bs_n = 4'hf;
		host_oe = 0;
		sel = SEL_OK;
	endtask

	function automatic sbc_pkg::sbc_word_t pv(input int k);
		return {k[3:0], 32'h5ca10000 + 32'(k)};
	endfunction

	function automatic sbc_pkg::sbc_word_t merge(input sbc_pkg::sbc_word_t o,
		input sbc_pkg::sbc_word_t n, input logic [3:0] ln);
		logic [35:0] m;
		m = {ln, {8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
		return (o & ~m) | (n & m);
	endfunction

	// Output enable goes high before the host drives, so the wires turn round cleanly
	task automatic wr(input logic ctrl, input logic [16:0] a, input sbc_pkg::sbc_word_t w,
		input logic [3:0] ln_n, input logic all_n, input logic [2:0] s);
		ad = a;
		sel = s;
		oe_n = 1;
		sp_n = ctrl;
		sc_n = !ctrl;
		if (!ctrl)
		begin
			tick();
			sp_n = 1;
		end
		gw_n = all_n;
		bwe_n = 0;
		bs_n = ln_n;
		host_w = w;
		host_oe = 1;
		tick();
		idle();
	endtask

	task automatic rd(input logic [16:0] a);
		ad = a;
		sp_n = 0;
		oe_n = 0;
		tick();
		sp_n = 1;
		check(wire_w, mem_e[int'(a)], "read word");
		check(36'({doe, poe}), 36'h3, "read drive");
	endtask

	task automatic burst(input logic order, input logic [16:0] a);
		logic [1:0] lsb;
		mode = order;
		tick();
		ad = a;
		sp_n = 0;
		oe_n = 0;
		for (int k = 0; k < 4; k++)
		begin
			tick();
			sp_n = 1;
			adv_n = 0;
			lsb = order ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
			check(wire_w, mem_e[int'({a[16:2], lsb})], "burst word");
		end
		idle();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios

	// Fill the word first so the processor-strobe read of it never returns unwritten cells
	task automatic t_lanes;
		wr(1, A0, pv(0), 4'h0, 1, SEL_OK);
		mem_e[A0] = pv(0);
		wr(0, A0, pv(1), 4'hf, 0, SEL_OK);
		mem_e[A0] = pv(1);
		rd(A0);
		for (int i = 0; i < 4; i++)
		begin
			wr(1, A0, pv(16 + i), ~(4'h1 << i), 1, SEL_OK);
			mem_e[A0] = merge(mem_e[A0], pv(16 + i), 4'h1 << i);
			rd(A0);
		end
		wr(1, A0, pv(9), 4'he, 0, SEL_OK);
		mem_e[A0] = pv(9);
		rd(A0);
		$display("done: lane writes");
	endtask

	// Both strobes low: only the processor strobe counts, so its write inputs are ignored
	task automatic t_strobes;
		ad = A0;
		sp_n = 0;
		sc_n = 0;
		gw_n = 0;
		oe_n = 1;
		host_w = pv(40);
		host_oe = 1;
		tick();
		idle();
		tick();
		rd(A0);
		for (int i = 0; i < 3; i++)
		begin
			wr(1, A0, pv(50 + i), 4'h0, 0, SEL_OK ^ (3'h1 << i));
			oe_n = 0;
			#1;
			check(36'(doe), 36'h0, "deselected drive");
		end
		rd(A0);
		$display("done: strobes and select");
	endtask

	task automatic t_turn;
		wr(1, A1, pv(60), 4'h0, 1, SEL_OK);
		mem_e[A1] = pv(60);
		rd(A1);
		oe_n = 1;
		#1;
		check(36'(doe), 36'h0, "enable off");
		oe_n = 0;
		#1;
		check(36'(doe), 36'h1, "enable on");
		gw_n = 0;
		host_w = pv(61);
		host_oe = 1;
		#1;
		check(36'(doe), 36'h0, "write float");
		tick();
		idle();
		mem_e[A1] = pv(61);
		rd(A1);
		$display("done: turnaround");
	endtask

	task automatic t_burst;
		for (int k = 0; k < 4; k++)
		begin
			wr(1, BASE + 17'(k), pv(70 + k), 4'h0, 1, SEL_OK);
			mem_e[BASE + k] = pv(70 + k);
		end
		for (int s = 0; s < 4; s++)
			burst(s[0], BASE + 17'(s));
		$display("done: bursts");
	endtask

	// The part is deselected before sleep and left alone for a while after it
	task automatic t_sleep;
		sel = 3'h0;
		sc_n = 0;
		tick();
		idle();
		zz = 1;
		repeat (3) tick();
		wr(1, A1, pv(90), 4'h0, 0, SEL_OK);
		ad = A1;
		sp_n = 0;
		oe_n = 0;
		tick();
		sp_n = 1;
		check(36'(doe), 36'h0, "drive in sleep");
		zz = 0;
		repeat (3) tick();
		rd(A1);
		check(36'(rdy), 36'h1, "buffer ready");
		$display("done: sleep");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock, hang guard and main sequence

	initial
	begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		wrap_up();
	end

	initial
	begin
		num_errors = 0;
		checks_done = 0;
		rst_n = 0;
		zz = 0;
		mode = 0;
		oe_n = 1;
		ad = '0;
		host_w = '0;
		idle();
		repeat (2) @(posedge core_clk);
		tick();
		rst_n = 1;
		check(36'({rdy, doe}), 36'h2, "after reset");
		t_lanes();
		t_strobes();
		t_turn();
		t_burst();
		t_sleep();
		check(36'(clash), 36'h0, "bus clash");
		wrap_up();
	end
endmodule
